// ===== hdl/ckb_regs.svh
// Constants for the classifier key field builder: offsets, codes and sizes.
`ifndef CKB_REGS_SVH
`define CKB_REGS_SVH

`define CKB_FRAME_BYTES 160
`define CKB_FW 1280
`define CKB_OVERLOADED_TYPE_FIELD_OFS 8'h0C
`define CKB_L3_SKIP 8'h02
`define CKB_MIN_OVERLOADED_TYPE_FIELD 16'h0600
`define CKB_ET_IPV4 16'h0800
`define CKB_ET_IPV6 16'h86DD
`define CKB_VER_IPV4 4'h4
`define CKB_VER_IPV6 4'h6
`define CKB_LLC_SNAP 24'hAAAA03
`define CKB_PROTO_TCP 8'h06
`define CKB_PROTO_UDP 8'h11
`define CKB_IHL_MIN 4'h5
`define CKB_LLC_CTRL_OFS 8'h02
`define CKB_SNAP_PID_OFS 8'h03
`define CKB_SNAP_PID_LO_OFS 8'h05
`define CKB_V4_DSCP_OFS 8'h01
`define CKB_V4_FLAGS_OFS 8'h06
`define CKB_V4_PROTO_OFS 8'h09
`define CKB_V4_SIP_OFS 8'h0C
`define CKB_V4_DIP_OFS 8'h10
`define CKB_V6_NH_OFS 8'h06
`define CKB_V6_SIP_OFS 8'h08
`define CKB_V6_DIP_OFS 8'h18
`define CKB_V6_HDR_LEN 8'h28
`define CKB_L4_DPORT_OFS 8'h02
`define CKB_RNG_NUM 8

`define CKB_REG_CTRL 8'h00
`define CKB_REG_STAT 8'h04
`define CKB_REG_RNG_BOUND 8'h20
`define CKB_REG_RNG_TYPE 8'h40
`define CKB_CTRL_RST 1'h0
`define CKB_RNG_TYPE_RST 3'h6

`endif

// ===== hdl/ckb_pkg.sv
// Types shared by the classifier key field builder modules.
package ckb_pkg;
	typedef enum logic [2:0] {
		CKB_RNG_SPORT,
		CKB_RNG_DPORT,
		CKB_RNG_EITHER,
		CKB_RNG_VID,
		CKB_RNG_DSCP,
		CKB_RNG_CUSTOM,
		CKB_RNG_OFF
	} ckb_rng_e;
endpackage

// ===== hdl/ckb_rng_if.sv
// Values offered to the range checkers by the key builder.
`timescale 1ns/1ps
`default_nettype none
interface ckb_rng_if;
	logic [15:0] sport;
	logic [15:0] dport;
	logic [11:0] vid;
	logic [5:0] dscp;
	logic [15:0] custom;
	modport provider (output sport, output dport, output vid, output dscp,
		output custom);
	modport checker_side (input sport, input dport, input vid, input dscp,
		input custom);
endinterface
`default_nettype wire

// ===== hdl/ckb_mel_therm.sv
// Thermometer code of a maintenance level for the source port key.
`timescale 1ns/1ps
`default_nettype none
module ckb_mel_therm (
	input wire logic [2:0] level_in,
	output logic [15:0] therm_out
);
	genvar g;
	generate
		for (g = 0; g < 16; g++)
		begin : g_bit
			assign therm_out[g] = (g < level_in);
		end
	endgenerate
endmodule // ckb_mel_therm
`default_nettype wire

// ===== hdl/ckb_rng_chk.sv
// One range checker comparing a selected frame value against bounds.
`timescale 1ns/1ps
`default_nettype none
module ckb_rng_chk (
	ckb_rng_if.checker_side vals,
	input wire logic [2:0] type_in,
	input wire logic [15:0] lo_in,
	input wire logic [15:0] hi_in,
	output logic match_out
);
	ckb_pkg::ckb_rng_e kind;
	wire sp_hit = (vals.sport >= lo_in) && (vals.sport <= hi_in);
	wire dp_hit = (vals.dport >= lo_in) && (vals.dport <= hi_in);
	wire vid_hit = ({4'h0, vals.vid} >= lo_in) && ({4'h0, vals.vid} <= hi_in);
	wire ds_hit = ({10'h000, vals.dscp} >= lo_in)
		&& ({10'h000, vals.dscp} <= hi_in);
	wire cu_hit = (vals.custom >= lo_in) && (vals.custom <= hi_in);
	assign kind = ckb_pkg::ckb_rng_e'(type_in);
	always_comb
	begin
		case (kind)
			ckb_pkg::CKB_RNG_SPORT: match_out = sp_hit;
			ckb_pkg::CKB_RNG_DPORT: match_out = dp_hit;
			ckb_pkg::CKB_RNG_EITHER: match_out = sp_hit | dp_hit;
			ckb_pkg::CKB_RNG_VID: match_out = vid_hit;
			ckb_pkg::CKB_RNG_DSCP: match_out = ds_hit;
			ckb_pkg::CKB_RNG_CUSTOM: match_out = cu_hit;
			default: match_out = 1'b0;
		endcase
	end
endmodule // ckb_rng_chk
`default_nettype wire

// ===== hdl/ckb_key_builder.sv
// Builds the layer-3, layer-4 and payload part of the lookup key.
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "ckb_regs.svh"
`default_nettype none
module ckb_key_builder (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wr_data_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rd_data_out,
	input wire logic frame_valid_in,
	input wire logic [`CKB_FW-1:0] frame_data_in,
	input wire logic [1:0] tag_count_in,
	input wire logic frame_is_eth_in,
	input wire logic [5:0] frame_ptr_in,
	input wire logic oam_y1731_in,
	input wire logic [2:0] maintenance_level_in,
	input wire logic [5:0] classified_dscp_in,
	input wire logic [5:0] remapped_dscp_in,
	input wire logic [11:0] vid_in,
	input wire logic [15:0] custom_value_in,
	output logic key_valid_out,
	output logic [15:0] overloaded_type_field_out,
	output logic ethertype_coded_flag_out,
	output logic ip_or_llc_encap_flag_out,
	output logic ipv4_frame_flag_out,
	output logic fragmented_flag_out,
	output logic later_fragment_flag_out,
	output logic header_options_flag_out,
	output logic [5:0] diffserv_key_field_out,
	output logic [127:0] dest_address_key_out,
	output logic [127:0] source_address_key_out,
	output logic transport_flag_out,
	output logic stream_transport_flag_out,
	output logic [15:0] source_port_key_out,
	output logic [7:0] range_match_mask_out,
	output logic [511:0] raw_payload_key_out
);
	default clocking @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	function automatic logic [7:0] fb(input logic [7:0] i);
		fb = frame_data_in[`CKB_FW-1-8*i -: 8];
	endfunction

	function automatic logic [15:0] fb16(input logic [7:0] i);
		fb16 = frame_data_in[`CKB_FW-1-8*i -: 16];
	endfunction

	function automatic logic [31:0] fb32(input logic [7:0] i);
		fb32 = frame_data_in[`CKB_FW-1-8*i -: 32];
	endfunction

	function automatic logic [127:0] fb128(input logic [7:0] i);
		fb128 = frame_data_in[`CKB_FW-1-8*i -: 128];
	endfunction

	// Matches a word address inside one of the per-checker register banks.
	function automatic logic in_bank(input logic [7:0] a, input logic [7:0] b);
		in_bank = (a[7:5] == b[7:5]);
	endfunction

	// Frame layout: EtherType position moves by four bytes per VLAN tag.
	wire [7:0] et_ofs = `CKB_OVERLOADED_TYPE_FIELD_OFS + {4'h0, tag_count_in, 2'b00};
	wire [7:0] l3 = et_ofs + `CKB_L3_SKIP;
	wire [15:0] type_len = fb16(et_ofs);
	wire [7:0] b_l3 = fb(l3);
	wire [7:0] b_l3p1 = fb(l3 + `CKB_V4_DSCP_OFS);
	wire [3:0] ip_ver = b_l3[7:4];
	wire [3:0] ihl = b_l3[3:0];

	wire et_coded = (type_len >= `CKB_MIN_OVERLOADED_TYPE_FIELD);
	wire is_v4 = et_coded && (type_len == `CKB_ET_IPV4)
		&& (ip_ver == `CKB_VER_IPV4);
	wire is_v6 = et_coded && (type_len == `CKB_ET_IPV6)
		&& (ip_ver == `CKB_VER_IPV6);
	wire is_ip = is_v4 | is_v6;
	wire is_snap = !et_coded
		&& ({b_l3, fb16(l3 + 8'h01)} == `CKB_LLC_SNAP);
	wire ip_or_llc_encap_flag = et_coded ? is_ip : is_snap;
	wire is_llc = !et_coded && !is_snap;

	wire [7:0] proto = is_v4 ? fb(l3 + `CKB_V4_PROTO_OFS)
		: fb(l3 + `CKB_V6_NH_OFS);
	wire is_tcp = is_ip && (proto == `CKB_PROTO_TCP);
	wire is_l4 = is_ip && ((proto == `CKB_PROTO_TCP)
		|| (proto == `CKB_PROTO_UDP));
	wire transport = is_l4 | oam_y1731_in;
	wire [7:0] l4 = is_v4 ? (l3 + {2'b00, ihl, 2'b00})
		: (l3 + `CKB_V6_HDR_LEN);

	wire [15:0] frag_word = fb16(l3 + `CKB_V4_FLAGS_OFS);
	wire frag_ofs_nz = (frag_word[12:0] != 13'h0000);
	wire fragmented = is_v4 && (frag_word[13] || frag_ofs_nz);
	wire later_frag = is_v4 && frag_ofs_nz;
	wire options = is_v4 && (ihl > `CKB_IHL_MIN);

	wire [5:0] frame_dscp = is_v4 ? b_l3p1[7:2]
		: (is_v6 ? {b_l3[3:0], b_l3p1[7:6]} : 6'h00);
	logic use_classified_diffserv_r;
	wire [5:0] dscp_sel = use_classified_diffserv_r ? classified_dscp_in
		: frame_dscp;

	wire [15:0] mel_therm;
	ckb_mel_therm u_mel (
		.level_in(maintenance_level_in),
		.therm_out(mel_therm)
	);
	wire [15:0] source_port_key = is_l4 ? fb16(l4) : 16'h0000;
	wire [15:0] l4_dport = is_l4 ? fb16(l4 + `CKB_L4_DPORT_OFS) : 16'h0000;
	wire [15:0] sport_key = oam_y1731_in ? mel_therm : source_port_key;

	logic [15:0] type_field;
	always_comb
	begin
		if (is_llc)
			type_field = {b_l3, fb(l3 + 8'h01)};
		else if (!et_coded)
			type_field = fb16(l3 + `CKB_SNAP_PID_OFS);
		else if (is_ip && is_l4)
			type_field = l4_dport;
		else if (is_ip)
			type_field = {8'h00, proto};
		else
			type_field = type_len;
	end

	wire [127:0] dip = is_v4 ? {96'h0, fb32(l3 + `CKB_V4_DIP_OFS)}
		: (is_v6 ? fb128(l3 + `CKB_V6_DIP_OFS) : 128'h0);

	logic [127:0] sip;
	always_comb
	begin
		if (is_llc)
			sip = fb128(l3 + `CKB_LLC_CTRL_OFS);
		else if (!et_coded)
			sip = fb128(l3 + `CKB_SNAP_PID_LO_OFS);
		else if (is_v4)
			sip = {96'h0, fb32(l3 + `CKB_V4_SIP_OFS)};
		else if (is_v6)
			sip = fb128(l3 + `CKB_V6_SIP_OFS);
		else
			sip = fb128(l3);
	end

	// The pointer is relative to the layer after the Ethernet header for Ethernet frames, else to the start of the frame.
	wire [7:0] pay_start = (frame_is_eth_in ? l3 : 8'h00)
		+ {2'b00, frame_ptr_in};
	wire [511:0] raw_pay = frame_data_in[`CKB_FW-1-8*pay_start -: 512];

	// Range checkers and their configuration registers.
	logic [31:0] rng_bound_r [`CKB_RNG_NUM];
	logic [2:0] rng_type_r [`CKB_RNG_NUM];
	wire [7:0] rng_hit;
	ckb_rng_if rng_vals ();
	assign rng_vals.sport = source_port_key;
	assign rng_vals.dport = l4_dport;
	assign rng_vals.vid = vid_in;
	assign rng_vals.dscp = remapped_dscp_in;
	assign rng_vals.custom = custom_value_in;

	genvar g;
	generate
		for (g = 0; g < `CKB_RNG_NUM; g++)
		begin : g_rng
			ckb_rng_chk u_chk (
				.vals(rng_vals.checker_side),
				.type_in(rng_type_r[g]),
				.lo_in(rng_bound_r[g][15:0]),
				.hi_in(rng_bound_r[g][31:16]),
				.match_out(rng_hit[g])
			);
		end
	endgenerate

	// Register port decode.
	wire wr_ctrl = wr_in && (addr_in == `CKB_REG_CTRL);
	wire wr_bound = wr_in && in_bank(addr_in, `CKB_REG_RNG_BOUND);
	wire wr_type = wr_in && in_bank(addr_in, `CKB_REG_RNG_TYPE);
	wire [2:0] rng_idx = addr_in[4:2];
	logic [15:0] key_count_r;

	logic [31:0] rd_data_nxt;
	always_comb
	begin
		rd_data_nxt = 32'h00000000;
		if (rd_in)
		begin
			if (addr_in == `CKB_REG_CTRL)
				rd_data_nxt = {31'h0, use_classified_diffserv_r};
			else if (addr_in == `CKB_REG_STAT)
				rd_data_nxt = {key_count_r, 8'h00, range_match_mask_out};
			else if (in_bank(addr_in, `CKB_REG_RNG_BOUND))
				rd_data_nxt = rng_bound_r[rng_idx];
			else if (in_bank(addr_in, `CKB_REG_RNG_TYPE))
				rd_data_nxt = {29'h0, rng_type_r[rng_idx]};
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			use_classified_diffserv_r <= `CKB_CTRL_RST;
			rd_data_out <= 32'h00000000;
		end
		else
		begin
			if (wr_ctrl)
				use_classified_diffserv_r <= wr_data_in[0];
			rd_data_out <= rd_data_nxt;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			for (int i = 0; i < `CKB_RNG_NUM; i++)
			begin
				rng_bound_r[i] <= 32'h00000000;
				rng_type_r[i] <= `CKB_RNG_TYPE_RST;
			end
		end
		else
		begin
			if (wr_bound)
				rng_bound_r[rng_idx] <= wr_data_in;
			if (wr_type)
				rng_type_r[rng_idx] <= wr_data_in[2:0];
		end
	end

	// Key outputs are captured one cycle after the frame is offered.
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			key_valid_out <= 1'b0;
			key_count_r <= 16'h0000;
		end
		else
		begin
			key_valid_out <= frame_valid_in;
			if (frame_valid_in)
				key_count_r <= key_count_r + 16'h0001;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			overloaded_type_field_out <= 16'h0000;
			ethertype_coded_flag_out <= 1'b0;
			ip_or_llc_encap_flag_out <= 1'b0;
			ipv4_frame_flag_out <= 1'b0;
			fragmented_flag_out <= 1'b0;
			later_fragment_flag_out <= 1'b0;
			header_options_flag_out <= 1'b0;
			diffserv_key_field_out <= 6'h00;
			dest_address_key_out <= 128'h0;
			source_address_key_out <= 128'h0;
			transport_flag_out <= 1'b0;
			stream_transport_flag_out <= 1'b0;
			source_port_key_out <= 16'h0000;
			range_match_mask_out <= 8'h00;
			raw_payload_key_out <= 512'h0;
		end
		else if (frame_valid_in)
		begin
			overloaded_type_field_out <= type_field;
			ethertype_coded_flag_out <= et_coded;
			ip_or_llc_encap_flag_out <= ip_or_llc_encap_flag;
			ipv4_frame_flag_out <= is_v4;
			fragmented_flag_out <= fragmented;
			later_fragment_flag_out <= later_frag;
			header_options_flag_out <= options;
			diffserv_key_field_out <= dscp_sel;
			dest_address_key_out <= dip;
			source_address_key_out <= sip;
			transport_flag_out <= transport;
			stream_transport_flag_out <= is_tcp;
			source_port_key_out <= sport_key;
			range_match_mask_out <= rng_hit;
			raw_payload_key_out <= raw_pay;
		end
	end

	AST_KEY_TIMING: assert property (
		frame_valid_in |=> key_valid_out)
		else $error("key valid did not follow frame valid");
	AST_IPV4_IMPLIES: assert property (
		ipv4_frame_flag_out |-> ethertype_coded_flag_out
		&& ip_or_llc_encap_flag_out
		&& (transport_flag_out || overloaded_type_field_out[15:8] == 8'h00))
		else $error("IPv4 flag without coded IP frame");
	AST_LATER_FRAG: assert property (
		later_fragment_flag_out |-> fragmented_flag_out && ipv4_frame_flag_out)
		else $error("later fragment without fragmented flag");
	AST_FRAG_V4: assert property (
		fragmented_flag_out |-> ipv4_frame_flag_out)
		else $error("fragmented flag on a non-IPv4 frame");
	AST_OPTIONS_V4: assert property (
		header_options_flag_out |-> ipv4_frame_flag_out)
		else $error("options flag on a non-IPv4 frame");
	AST_STREAM: assert property (
		stream_transport_flag_out |-> transport_flag_out
		&& ip_or_llc_encap_flag_out)
		else $error("stream transport without transport flag");
	AST_V4_DIP_HIGH: assert property (
		ipv4_frame_flag_out |-> dest_address_key_out[127:32] == 96'h0
		&& source_address_key_out[127:32] == 96'h0)
		else $error("upper address bits not zero for IPv4");
	AST_OAM_PORT: assert property (
		frame_valid_in && oam_y1731_in |=> transport_flag_out
		&& source_port_key_out == ((16'h0001 << $past(maintenance_level_in))
		- 16'h0001))
		else $error("OAM source port key or transport flag wrong");
	AST_DSCP_SEL: assert property (
		frame_valid_in && use_classified_diffserv_r
		|=> diffserv_key_field_out == $past(classified_dscp_in))
		else $error("classified diffserv not selected");
	AST_ETCODE: assert property (
		frame_valid_in |=> ethertype_coded_flag_out
		== ($past(type_len) >= `CKB_MIN_OVERLOADED_TYPE_FIELD))
		else $error("EtherType coded flag wrong");
	AST_HOLD: assert property (
		!frame_valid_in |=> $stable(overloaded_type_field_out))
		else $error("type field changed without a frame");
endmodule // ckb_key_builder
`default_nettype wire

// ===== verif/ckb_frame_src.sv
// Model of the upstream frame parser that offers frames to the key builder.
`timescale 1ns/1ps
`default_nettype none
module ckb_frame_src (
	input wire logic clk_in,
	output logic frame_valid_out,
	output logic [1279:0] frame_data_out,
	output logic [1:0] tag_count_out
);
	logic [7:0] fb [160];

	initial
	begin
		frame_valid_out = 1'b0;
		frame_data_out = '0;
		tag_count_out = 2'h0;
	end

	task automatic clr();
		foreach (fb[i])
			fb[i] = 8'h00;
	endtask

	task automatic put(input int ofs, input logic [31:0] val, input int n);
		for (int i = 0; i < n; i++)
			fb[ofs + i] = val[8 * (n - 1 - i) +: 8];
	endtask

	// Once the frame is taken the data lines no longer hold it.
	task automatic send(input logic [1:0] tags);
		logic [1279:0] d;
		for (int i = 0; i < 160; i++)
			d[1279 - 8 * i -: 8] = fb[i];
		@(posedge clk_in);
		frame_valid_out <= 1'b1;
		tag_count_out <= tags;
		frame_data_out <= d;
		@(posedge clk_in);
		frame_valid_out <= 1'b0;
		frame_data_out <= ~d;
	endtask
endmodule // ckb_frame_src
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the classifier key field builder.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk;
	logic rst_n;
	logic [7:0] addr;
	logic [31:0] wdat;
	logic wr_s;
	logic rd_s;
	logic is_eth;
	logic [5:0] ptr;
	logic oam;
	logic [2:0] mel;
	logic [5:0] cdscp;
	logic [5:0] rdscp;
	logic [11:0] vid;
	logic [15:0] cust;
	int err_count;
	int total_checks;
	wire logic [31:0] rdat;
	wire logic fv;
	wire logic [1279:0] fd;
	wire logic [1:0] tags;
	wire logic kv;
	wire logic [15:0] otype;
	wire logic f_et, f_ip, f_v4, f_fr, f_lf, f_op, f_tr, f_st;
	wire logic [7:0] flags;
	wire logic [5:0] dsrv;
	wire logic [127:0] dip;
	wire logic [127:0] sip;
	wire logic [15:0] sport;
	wire logic [7:0] mask;
	wire logic [511:0] raw;
	assign flags = {f_et, f_ip, f_v4, f_fr, f_lf, f_op, f_tr, f_st};

	ckb_frame_src ckb_frame_src_i (.clk_in(clk), .frame_valid_out(fv),
		.frame_data_out(fd), .tag_count_out(tags));

	ckb_key_builder ckb_key_builder_i (.ref_clk_in(clk), .rst_n_in(rst_n),
		.addr_in(addr), .wr_data_in(wdat), .wr_in(wr_s), .rd_in(rd_s),
		.rd_data_out(rdat), .frame_valid_in(fv), .frame_data_in(fd),
		.tag_count_in(tags), .frame_is_eth_in(is_eth), .frame_ptr_in(ptr),
		.oam_y1731_in(oam), .maintenance_level_in(mel),
		.classified_dscp_in(cdscp), .remapped_dscp_in(rdscp), .vid_in(vid),
		.custom_value_in(cust), .key_valid_out(kv),
		.overloaded_type_field_out(otype), .ethertype_coded_flag_out(f_et),
		.ip_or_llc_encap_flag_out(f_ip), .ipv4_frame_flag_out(f_v4),
		.fragmented_flag_out(f_fr), .later_fragment_flag_out(f_lf),
		.header_options_flag_out(f_op), .diffserv_key_field_out(dsrv),
		.dest_address_key_out(dip), .source_address_key_out(sip),
		.transport_flag_out(f_tr), .stream_transport_flag_out(f_st),
		.source_port_key_out(sport), .range_match_mask_out(mask),
		.raw_payload_key_out(raw));

	always #10 clk = ~clk;

	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic give_verdict();
		$display("checks=%0d errors=%0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdat <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		chk(rdat, exp);
	endtask

	// Sends the staged frame and checks the one-cycle key strobe.
	task automatic fr(input logic [1:0] t);
		ckb_frame_src_i.send(t);
		#1;
		chk(kv, 1'b1);
		@(posedge clk);
		#1;
		chk(kv, 1'b0);
	endtask

	task automatic t_ipv4_tcp();
		rd_chk(8'h00, 32'h00000000);
		wr(8'h20, 32'h20001000);
		wr(8'h40, 32'h00000000);
		ckb_frame_src_i.clr();
		ckb_frame_src_i.put(12, 32'h0800, 2);
		ckb_frame_src_i.put(14, 32'h46A8, 2);
		ckb_frame_src_i.put(20, 32'h20, 1);
		ckb_frame_src_i.put(23, 32'h06, 1);
		ckb_frame_src_i.put(26, 32'hC0A80001, 4);
		ckb_frame_src_i.put(30, 32'h0A000002, 4);
		ckb_frame_src_i.put(38, 32'h12340050, 4);
		fr(2'h0);
		chk(otype, 16'h0050);
		chk(flags, 8'hF7);
		chk(f_fr, 1'b1);
		chk(dsrv, 6'h2A);
		chk(dip, 128'h0A000002);
		chk(sip, 128'hC0A80001);
		chk(sport, 16'h1234);
		chk(mask, 8'h01);
		chk(raw[511:480], 32'h46A80000);
		rd_chk(8'h04, 32'h00010001);
		rd_chk(8'h80, 32'h00000000);
	endtask

	task automatic t_ipv4_udp();
		wr(8'h00, 32'h00000001);
		cdscp <= 6'h15;
		ptr <= 6'h02;
		ckb_frame_src_i.clr();
		ckb_frame_src_i.put(16, 32'h0800, 2);
		ckb_frame_src_i.put(18, 32'h45FC, 2);
		ckb_frame_src_i.put(20, 32'h11223344, 4);
		ckb_frame_src_i.put(24, 32'h0001, 2);
		ckb_frame_src_i.put(27, 32'h11, 1);
		ckb_frame_src_i.put(38, 32'h00351000, 4);
		fr(2'h1);
		chk(otype, 16'h1000);
		chk(flags, 8'hFA);
		chk(dsrv, 6'h15);
		chk(sport, 16'h0035);
		chk(mask, 8'h00);
		chk(raw[511:480], 32'h11223344);
		wr(8'h00, 32'h00000000);
		ptr <= 6'h00;
	endtask

	task automatic t_llc_snap();
		is_eth <= 1'b0;
		ckb_frame_src_i.clr();
		ckb_frame_src_i.put(0, 32'hCAFE0001, 4);
		ckb_frame_src_i.put(12, 32'h0040, 2);
		ckb_frame_src_i.put(14, 32'hF0F103A1, 4);
		ckb_frame_src_i.put(18, 32'hA2A3, 2);
		fr(2'h0);
		chk(otype, 16'hF0F1);
		chk(flags, 8'h00);
		chk(sip[127:96], 32'h03A1A2A3);
		chk(dip, 128'h0);
		chk(raw[511:480], 32'hCAFE0001);
		is_eth <= 1'b1;
		ckb_frame_src_i.put(14, 32'hAAAA0388, 4);
		ckb_frame_src_i.put(18, 32'h99AABBCC, 4);
		ckb_frame_src_i.put(22, 32'h5A, 1);
		fr(2'h0);
		chk(otype, 16'h8899);
		chk(flags, 8'h40);
		chk(sip[127:96], 32'hAABBCC5A);
	endtask

	task automatic t_other();
		ckb_frame_src_i.clr();
		ckb_frame_src_i.put(12, 32'h05FF, 2);
		fr(2'h0);
		chk(f_et, 1'b0);
		ckb_frame_src_i.put(12, 32'h0600, 2);
		fr(2'h0);
		chk(flags, 8'h80);
		ckb_frame_src_i.put(12, 32'h0800, 2);
		ckb_frame_src_i.put(14, 32'h60, 1);
		ckb_frame_src_i.put(20, 32'h20, 1);
		ckb_frame_src_i.put(23, 32'h06, 1);
		fr(2'h0);
		chk(otype, 16'h0800);
		chk(flags, 8'h80);
		ckb_frame_src_i.clr();
		ckb_frame_src_i.put(24, 32'h8902, 2);
		ckb_frame_src_i.put(26, 32'h01020304, 4);
		oam <= 1'b1;
		for (int n = 0; n < 8; n++)
		begin
			mel <= n[2:0];
			fr(2'h3);
			chk(sport, (16'h0001 << n) - 16'h0001);
		end
		chk(otype, 16'h8902);
		chk(flags, 8'h82);
		chk(sip[127:96], 32'h01020304);
		oam <= 1'b0;
	endtask

	// IPv6 frames with every range checker kind armed.
	task automatic t_ipv6();
		wr(8'h24, 32'h00200010);
		wr(8'h44, 32'h00000004);
		wr(8'h28, 32'h01FF0100);
		wr(8'h48, 32'h00000003);
		wr(8'h2C, 32'h00030002);
		wr(8'h4C, 32'h00000005);
		wr(8'h30, 32'h00000000);
		wr(8'h50, 32'h00000001);
		wr(8'h34, 32'h00000000);
		wr(8'h54, 32'h00000002);
		rd_chk(8'h48, 32'h00000003);
		rdscp <= 6'h18;
		vid <= 12'h123;
		cust <= 16'h0001;
		ckb_frame_src_i.clr();
		ckb_frame_src_i.put(12, 32'h86DD, 2);
		ckb_frame_src_i.put(14, 32'h6A40, 2);
		ckb_frame_src_i.put(20, 32'h3A, 1);
		ckb_frame_src_i.put(22, 32'h20010DB8, 4);
		ckb_frame_src_i.put(34, 32'h00000001, 4);
		ckb_frame_src_i.put(38, 32'hFE800000, 4);
		ckb_frame_src_i.put(50, 32'h00000002, 4);
		fr(2'h0);
		chk(otype, 16'h003A);
		chk(flags, 8'hC0);
		chk(dsrv, 6'h29);
		chk(sip, 128'h20010DB8000000000000000000000001);
		chk(dip, 128'hFE800000000000000000000000000002);
		chk(sport, 16'h0000);
		chk(mask, 8'h36);
		chk(raw[511:480], 32'h6A400000);
		ckb_frame_src_i.put(20, 32'h06, 1);
		ckb_frame_src_i.put(54, 32'hABCD0016, 4);
		fr(2'h0);
		chk(otype, 16'h0016);
		chk(flags, 8'hC3);
		chk(sport, 16'hABCD);
		chk(mask, 8'h06);
	endtask

	initial
	begin
		#1000000;
		err_count++;
		give_verdict();
	end

	initial
	begin
		clk = 1'b0;
		rst_n = 1'b0;
		addr = 8'h00;
		wdat = 32'h00000000;
		wr_s = 1'b0;
		rd_s = 1'b0;
		is_eth = 1'b1;
		ptr = 6'h00;
		oam = 1'b0;
		mel = 3'h0;
		cdscp = 6'h00;
		rdscp = 6'h00;
		vid = 12'h000;
		cust = 16'h0000;
		err_count = 0;
		total_checks = 0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_ipv4_tcp();
		t_ipv4_udp();
		t_llc_snap();
		t_other();
		t_ipv6();
		give_verdict();
	end
endmodule // tb_top
`default_nettype wire
